// ==== fwc_pkg.sv ====
//------------------------------------------------------------
// fwc_pkg: constants and types of the update command handler
//------------------------------------------------------------
package fwc_pkg;
	// command codes
	localparam logic [7:0] CMD_RD_ADDR = 8'hFD;
	localparam logic [7:0] CMD_STATUS = 8'hFC;
	localparam logic [7:0] CMD_EXIT = 8'hF1;
	localparam logic [7:0] CMD_INFO = 8'hEF;
	// status codes
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_CSUM = 8'h01;
	localparam logic [7:0] ST_BLOCK = 8'h02;
	localparam logic [7:0] ST_LEN = 8'h03;
	localparam logic [7:0] ST_WR_RO = 8'h04;
	localparam logic [7:0] ST_RD_WO = 8'h05;
	localparam logic [7:0] ST_CMD = 8'h06;
	localparam logic [7:0] ST_MODEL = 8'h0B;
	localparam logic [7:0] ST_ERASE_ERR = 8'h0C;
	localparam logic [7:0] ST_ERASE_OK = 8'h0D;
	localparam logic [7:0] ST_ACTIVE_UPD = 8'h54;
	localparam logic [7:0] ST_ERASE_BUSY = 8'h55;
	localparam logic [7:0] ST_WR_BUSY = 8'h56;
	localparam logic [7:0] ST_ADDR_OOB = 8'h57;
	localparam logic [7:0] ST_ADDR_SEQ = 8'h58;
	localparam logic [7:0] ST_VENDOR_LO = 8'hF0;
	localparam logic [7:0] ST_RESET = 8'h00;
	// argument counts and reply lengths
	localparam logic [2:0] RD_ADDR_COUNT = 3'h2;
	localparam logic [2:0] INFO_COUNT = 3'h1;
	localparam logic [7:0] RD_BLOCK_LEN = 8'h08;
	localparam logic [7:0] INFO_REPLY_LEN = 8'h09;
	localparam logic [3:0] RD_LAST_IDX = 4'h9;
	localparam logic [3:0] ST_LAST_IDX = 4'h1;
	localparam logic [3:0] INFO_LAST_IDX = 4'hA;
	// exit modes and regions
	localparam logic [7:0] MODE_BOOT = 8'h00;
	localparam logic [7:0] MODE_IMG_A = 8'h01;
	localparam logic [7:0] MODE_IMG_B = 8'h02;
	localparam logic [7:0] MODE_LEAVE = 8'h03;
	localparam logic [1:0] REG_BOOT = 2'h0;
	localparam logic [1:0] REG_IMG_A = 2'h1;
	localparam logic [1:0] REG_IMG_B = 2'h2;
	localparam logic [1:0] ACTIVE_RESET = 2'h1;
	// info selectors
	localparam logic [7:0] SEL_BOOT = 8'h00;
	localparam logic [7:0] SEL_IMG_A = 8'h0A;
	localparam logic [7:0] SEL_IMG_B = 8'h0B;
	localparam int FIFO_DEPTH = 2;

	// byte event from the bus front end
	typedef struct packed {
		logic start; // start or repeated start, next byte is address
		logic stop;
		logic valid;
		logic [7:0] data;
	} fwc_rx_t;

	// image load request towards the boot logic
	typedef struct packed {
		logic req;
		logic [1:0] region;
	} fwc_load_t;

	// eight-bit truncated sum
	function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0];
	endfunction : csum_add
endpackage : fwc_pkg

// ==== fwc_fifo.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------
// fwc_fifo: two-entry byte buffer on the reply path
//------------------------------------------------------------
module fwc_fifo import fwc_pkg::*; #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem [FIFO_DEPTH];
	logic [W-1:0] next_mem [FIFO_DEPTH];
	logic wp, rp, next_wp, next_rp;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	// handshakes
	assign in_ready_o = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o = mem[rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// pointer and count update
	always_comb begin
		next_mem = mem;
		next_wp = wp;
		next_rp = rp;
		next_cnt = cnt;
		if (flush_i) begin
			next_wp = 1'b0;
			next_rp = 1'b0;
			next_cnt = 2'h0;
		end else begin
			if (push) begin
				next_mem[wp] = in_data_i;
				next_wp = ~wp;
			end
			if (pop) begin
				next_rp = ~rp;
			end
			next_cnt = cnt + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem <= '{default: '0};
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			mem <= next_mem;
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
endmodule : fwc_fifo

// ==== fwc_top.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------
// fwc_top: firmware update command interpreter
//------------------------------------------------------------
module fwc_top import fwc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire fwc_rx_t rx_i,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] tx_data_o,
	input wire logic [7:0] page_i,
	output logic mem_req_o,
	output logic [23:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [7:0] mem_data_i,
	input wire logic upd_valid_i,
	input wire logic [7:0] upd_code_i,
	output logic [7:0] status_o,
	output logic cmd_fail_o,
	output fwc_load_t load_o,
	input wire logic load_done_i,
	input wire logic load_ok_i,
	output logic [1:0] active_o,
	output logic exit_prog_o,
	output logic [7:0] info_sel_o,
	input wire logic [63:0] info_rev_i
);
	//------------------------------------------------------------
	// transaction state
	//------------------------------------------------------------
	typedef enum {S_IDLE, S_ADDR, S_CMD, S_ARG, S_RD, S_SKIP} fwc_state_t;
	typedef enum {L_IDLE, L_WAIT, L_REVERT} fwc_load_state_t;

	fwc_state_t st, next_st;
	logic [7:0] cmd, next_cmd;
	logic [7:0] arg [3];
	logic [7:0] next_arg [3];
	logic [2:0] nargs, next_nargs;
	logic [7:0] sum, next_sum;
	logic [3:0] idx, next_idx;
	logic [15:0] rd_addr, next_rd_addr;
	logic [7:0] status, next_status;
	logic fail, next_fail;
	logic exit_p, next_exit_p;
	logic [7:0] sel, next_sel;
	logic mreq, next_mreq;
	logic [23:0] maddr, next_maddr;
	fwc_load_state_t lst, next_lst;
	logic [1:0] active, next_active;
	logic [1:0] prev, next_prev;
	fwc_load_t load, next_load;
	logic start_load;
	logic [1:0] start_region;
	logic push;
	logic [7:0] push_data;
	logic buf_ready;
	logic [3:0] last_idx;
	logic need_mem;
	logic [1:0] running;

	//------------------------------------------------------------
	// reply byte generation
	//------------------------------------------------------------
	// region currently executing; bootloader while a load runs
	assign running = (lst != L_IDLE) ? REG_BOOT : active;

	function automatic logic [1:0] sel_region(input logic [7:0] s);
		case (s)
			SEL_IMG_A: return REG_IMG_A;
			SEL_IMG_B: return REG_IMG_B;
			default: return REG_BOOT;
		endcase
	endfunction : sel_region

	// last reply index per command
	always_comb begin
		case (cmd)
			CMD_RD_ADDR: last_idx = RD_LAST_IDX;
			CMD_STATUS: last_idx = ST_LAST_IDX;
			default: last_idx = INFO_LAST_IDX;
		endcase
	end

	assign need_mem = (cmd == CMD_RD_ADDR) && (idx != 4'h0) && (idx != RD_LAST_IDX);

	// byte for the current reply index
	always_comb begin
		push_data = sum; // checksum at the last index
		if (idx != last_idx) begin
			case (cmd)
				CMD_RD_ADDR: push_data = (idx == 4'h0) ? RD_BLOCK_LEN : mem_data_i;
				CMD_STATUS: push_data = status;
				default: begin
					if (idx == 4'h0) begin
						push_data = INFO_REPLY_LEN;
					end else if (idx == 4'h1) begin
						push_data = {7'h00, running == sel_region(sel)};
					end else begin
						push_data = info_rev_i[8*(idx-4'h2) +: 8];
					end
				end
			endcase
		end
	end

	// push when buffer has room; data bytes wait for memory
	assign push = (st == S_RD) && buf_ready && (need_mem ? mem_ack_i : 1'b1);

	fwc_fifo #(.W(8)) u_buf (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(rx_i.start || rx_i.stop),
		.in_valid_i(push),
		.in_ready_o(buf_ready),
		.in_data_i(push_data),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.out_data_o(tx_data_o)
	);

	//------------------------------------------------------------
	// transaction decoder and command execution
	//------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_cmd = cmd;
		next_arg = arg;
		next_nargs = nargs;
		next_sum = sum;
		next_idx = idx;
		next_rd_addr = rd_addr;
		next_status = status;
		next_fail = 1'b0;
		next_exit_p = 1'b0;
		next_sel = sel;
		next_mreq = 1'b0;
		next_maddr = maddr;
		start_load = 1'b0;
		start_region = active;
		// a repeated start also closes the write phase, so a read that follows sees its arguments
		if (rx_i.start || rx_i.stop) begin
			next_st = S_IDLE;
			if (rx_i.start) begin
				next_st = S_ADDR;
			end
			if (st == S_ARG || st == S_CMD) begin
				case (cmd)
					CMD_RD_ADDR: begin
						if (nargs == 3'h3 && arg[0] == {5'h00, RD_ADDR_COUNT}) begin
							next_rd_addr = {arg[1], arg[2]};
							next_status = ST_OK;
						end else begin
							next_status = ST_LEN;
						end
					end
					CMD_STATUS: begin
						if (nargs == 3'h1 && arg[0] == 8'h00) begin
							next_status = ST_RESET;
						end else if (nargs != 3'h0) begin
							next_fail = 1'b1;
						end
					end
					CMD_EXIT: begin
						if (nargs != 3'h2) begin
							next_status = ST_LEN;
						end else if (csum_add(sum - arg[1], 8'h00) != arg[1]) begin
							next_status = ST_CSUM;
						end else if (arg[0] == MODE_LEAVE) begin
							next_exit_p = 1'b1;
							next_status = ST_OK;
						end else if (arg[0] > MODE_LEAVE || lst != L_IDLE) begin
							next_status = ST_CMD;
						end else begin
							// accepted only while no load is running
							next_exit_p = 1'b1;
							next_status = ST_OK;
							start_load = 1'b1;
							case (arg[0])
								MODE_IMG_A: start_region = REG_IMG_A;
								MODE_IMG_B: start_region = REG_IMG_B;
								default: start_region = active;
							endcase
						end
					end
					CMD_INFO: begin
						if (nargs == 3'h2 && arg[0] == {5'h00, INFO_COUNT} &&
							(arg[1] == SEL_IMG_A || arg[1] == SEL_IMG_B || arg[1] == SEL_BOOT)) begin
							next_sel = arg[1];
							next_status = ST_OK;
						end else begin
							next_status = ST_CMD;
						end
					end
					default: begin
					end
				endcase
			end
		end else begin
			case (st)
				S_IDLE: begin
				end
				S_ADDR: begin
					if (rx_i.valid) begin
						if (!rx_i.data[0]) begin
							next_sum = rx_i.data;
							next_nargs = 3'h0;
							next_st = S_CMD;
						end else if ((cmd == CMD_RD_ADDR || cmd == CMD_STATUS || cmd == CMD_INFO)
							&& nargs != 3'h7) begin
							next_sum = csum_add(sum, rx_i.data);
							next_idx = 4'h0;
							next_st = S_RD;
						end else begin
							if (cmd == CMD_EXIT) begin
								next_status = ST_RD_WO;
							end
							next_st = S_SKIP;
						end
					end
				end
				S_CMD: begin
					if (rx_i.valid) begin
						next_cmd = rx_i.data;
						next_sum = csum_add(sum, rx_i.data);
						next_st = S_ARG;
					end
				end
				S_ARG: begin
					if (rx_i.valid) begin
						if (nargs < 3'h3) begin
							next_arg[nargs[1:0]] = rx_i.data;
						end
						if (nargs != 3'h7) begin
							next_nargs = nargs + 3'h1;
						end
						next_sum = csum_add(sum, rx_i.data);
					end
				end
				S_RD: begin
					// one shot per transaction, stays put after checksum
					next_nargs = 3'h7;
					if (need_mem && !mem_ack_i) begin
						next_mreq = buf_ready;
						next_maddr = {page_i, rd_addr + {12'h000, idx - 4'h1}};
					end
					if (push) begin
						next_sum = csum_add(sum, push_data);
						if (idx == last_idx) begin
							next_st = S_SKIP;
						end else begin
							next_idx = idx + 4'h1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// outcome from other update commands; event wins over a clear
		if (upd_valid_i) begin
			next_status = upd_code_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= S_IDLE;
			cmd <= 8'h00;
			arg <= '{default: '0};
			nargs <= 3'h0;
			sum <= 8'h00;
			idx <= 4'h0;
			rd_addr <= 16'h0000;
			status <= ST_RESET;
			fail <= 1'b0;
			exit_p <= 1'b0;
			sel <= SEL_BOOT;
			mreq <= 1'b0;
			maddr <= 24'h000000;
		end else begin
			st <= next_st;
			cmd <= next_cmd;
			arg <= next_arg;
			nargs <= next_nargs;
			sum <= next_sum;
			idx <= next_idx;
			rd_addr <= next_rd_addr;
			status <= next_status;
			fail <= next_fail;
			exit_p <= next_exit_p;
			sel <= next_sel;
			mreq <= next_mreq;
			maddr <= next_maddr;
		end
	end

	//------------------------------------------------------------
	// image load and fallback
	//------------------------------------------------------------
	always_comb begin
		next_lst = lst;
		next_active = active;
		next_prev = prev;
		next_load = '{req: 1'b0, region: load.region};
		case (lst)
			L_IDLE: begin
				if (start_load) begin
					next_prev = active;
					next_load = '{req: 1'b1, region: start_region};
					next_lst = L_WAIT;
				end
			end
			L_WAIT: begin
				if (load_done_i) begin
					if (load_ok_i) begin
						next_active = load.region;
						next_lst = L_IDLE;
					end else begin
						next_load = '{req: 1'b1, region: prev};
						next_lst = L_REVERT;
					end
				end
			end
			L_REVERT: begin
				if (load_done_i) begin
					next_active = prev;
					next_lst = L_IDLE;
				end
			end
			default: next_lst = L_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lst <= L_IDLE;
			active <= ACTIVE_RESET;
			prev <= ACTIVE_RESET;
			load <= '{req: 1'b0, region: ACTIVE_RESET};
		end else begin
			lst <= next_lst;
			active <= next_active;
			prev <= next_prev;
			load <= next_load;
		end
	end

	assign status_o = status;
	assign cmd_fail_o = fail;
	assign exit_prog_o = exit_p;
	assign info_sel_o = sel;
	assign mem_req_o = mreq;
	assign mem_addr_o = maddr;
	assign load_o = load;
	assign active_o = active;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_rdaddr_latch: assert property (st == S_ARG && cmd == CMD_RD_ADDR && nargs == 3'h3 && arg[0] == 8'h02
		&& (rx_i.stop || rx_i.start) |=> rd_addr == $past({arg[1], arg[2]})) else $error("read address not latched");
	a_rd_count: assert property (push && cmd == CMD_RD_ADDR && idx == 4'h0 |-> push_data == 8'h08)
		else $error("block count not eight");
	a_status_clear: assert property (st == S_ARG && cmd == CMD_STATUS && nargs == 3'h1
		&& arg[0] == 8'h00 && rx_i.stop && !rx_i.start && !upd_valid_i |=> status_o == 8'h00)
		else $error("status not cleared");
	a_status_keep: assert property (st == S_ARG && cmd == CMD_STATUS && nargs == 3'h1
		&& arg[0] != 8'h00 && rx_i.stop && !rx_i.start && !upd_valid_i |=> cmd_fail_o && $stable(status_o))
		else $error("non-zero status write accepted");
	a_status_capture: assert property (upd_valid_i |=> status_o == $past(upd_code_i))
		else $error("update outcome not captured");
	a_exit_csum: assert property (load_o.req |-> $past(lst) != L_IDLE
		|| $past(arg[1]) == $past(sum - arg[1])) else $error("load started with bad checksum");
	a_leave_noload: assert property (exit_prog_o && lst == L_IDLE |-> !load_o.req)
		else $error("leave-only mode reset firmware");
	a_active_update: assert property (lst == L_WAIT && load_done_i && load_ok_i
		|=> active_o == $past(load_o.region)) else $error("active image not updated");
	a_revert: assert property (lst == L_WAIT && load_done_i && !load_ok_i
		|=> load_o.req ##0 load_o.region == prev) else $error("no revert after failed load");
	a_page_high: assert property (mem_req_o |-> mem_addr_o[23:16] == $past(page_i))
		else $error("page not top address byte");

	c_block_read: cover property (push && cmd == CMD_RD_ADDR && idx == RD_LAST_IDX);
	c_status_read: cover property (push && cmd == CMD_STATUS && idx == ST_LAST_IDX);
	c_revert: cover property (lst == L_REVERT && load_done_i);
	c_info_read: cover property (push && cmd == CMD_INFO && idx == INFO_LAST_IDX);
endmodule : fwc_top

// ==== fwc_host_model.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------
// fwc_host_model: host side of the byte and reply channels
//------------------------------------------------------------
module fwc_host_model import fwc_pkg::*; #(
	parameter logic [7:0] ADDR_R = 8'hB1 // arbitrary slave address, read bit set
) (
	input wire logic clk_i,
	output fwc_rx_t rx_o,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	logic [7:0] got[$];
	initial begin
		rx_o = '0;
		tx_ready_o = 1'b0;
	end
	// random stalls while taking reply bytes
	always @(negedge clk_i) begin
		tx_ready_o <= ($urandom_range(3) != 0);
	end
	// collect every reply byte that leaves the buffer
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			got.push_back(tx_data_i);
		end
	end
	// one event for one cycle; idle data keeps changing
	task automatic ev(input logic s, input logic p, input logic v, input logic [7:0] d);
		@(negedge clk_i);
		rx_o <= {s, p, v, v ? d : 8'($urandom)};
	endtask : ev
	// write phase, then an optional read phase of n bytes
	task automatic xfer(input logic [7:0] wr[$], input int n, output logic [7:0] rd[$]);
		int t;
		got.delete();
		ev(1'b1, 1'b0, 1'b0, 8'h00);
		foreach (wr[i]) ev(1'b0, 1'b0, 1'b1, wr[i]);
		if (n > 0) begin
			ev(1'b1, 1'b0, 1'b0, 8'h00);
			ev(1'b0, 1'b0, 1'b1, ADDR_R);
			ev(1'b0, 1'b0, 1'b0, 8'h00);
			t = 0;
			while (got.size() < n && t < 200) begin
				@(negedge clk_i);
				t++;
			end
		end
		ev(1'b0, 1'b1, 1'b0, 8'h00);
		ev(1'b0, 1'b0, 1'b0, 8'h00);
		rd = got;
	endtask : xfer
endmodule : fwc_host_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench import fwc_pkg::*; ();
	localparam logic [7:0] AW = 8'hB0; // arbitrary slave address, write
	localparam logic [7:0] AR = 8'hB1;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	fwc_rx_t rx;
	fwc_load_t load;
	logic tx_valid, tx_ready, mem_req, cmd_fail, exit_prog, cool;
	logic mem_ack = 1'b0;
	logic upd_valid = 1'b0;
	logic load_done = 1'b0;
	logic load_ok = 1'b0;
	logic [7:0] tx_data, status, info_sel, mid, low;
	logic [7:0] page = 8'h00;
	logic [7:0] mem_data = 8'h00;
	logic [7:0] upd_code = 8'h00;
	logic [23:0] mem_addr;
	logic [1:0] active;
	logic [63:0] info_rev = '0;
	logic [1:0] regions[$];
	logic [7:0] wr[$], rd[$], ex[$];
	int mismatches, tests_run, cycles, fails, exits, lcnt, fail_next;
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	fwc_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_i(rx), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.tx_data_o(tx_data), .page_i(page), .mem_req_o(mem_req), .mem_addr_o(mem_addr), .mem_ack_i(mem_ack),
		.mem_data_i(mem_data), .upd_valid_i(upd_valid), .upd_code_i(upd_code), .status_o(status),
		.cmd_fail_o(cmd_fail), .load_o(load), .load_done_i(load_done), .load_ok_i(load_ok), .active_o(active),
		.exit_prog_o(exit_prog), .info_sel_o(info_sel), .info_rev_i(info_rev));
	fwc_host_model #(.ADDR_R(AR)) u_host (.clk_i(clk_i), .rx_o(rx), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready));
	//------------------------------------------------------------
	// memory, boot loader and pulse counters
	//------------------------------------------------------------
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		return (a[7:0] ^ a[23:16]) + a[15:8] + 8'h35;
	endfunction : mem_byte
	function automatic logic [7:0] bsum(input logic [7:0] q[$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[i]) s += q[i];
		return s;
	endfunction : bsum
	// memory answers after a random delay, one ack per request
	always @(negedge clk_i) begin
		if (mem_req && !mem_ack && !cool && $urandom_range(1)) begin
			mem_ack <= 1'b1;
			mem_data <= mem_byte(mem_addr);
		end else begin
			mem_ack <= 1'b0;
			mem_data <= 8'($urandom);
		end
		cool <= mem_ack;
	end
	// image loads finish three cycles after the request
	always @(negedge clk_i) begin
		load_done <= 1'b0;
		load_ok <= 1'($urandom);
		if (load.req) begin
			regions.push_back(load.region);
			lcnt = 3;
		end else if (lcnt > 0) begin
			lcnt--;
			if (lcnt == 0) begin
				load_done <= 1'b1;
				load_ok <= (fail_next == 0);
				fail_next = 0;
			end
		end
	end
	// pulse counters and hang guard
	always @(posedge clk_i) begin
		fails += int'(cmd_fail === 1'b1);
		exits += int'(exit_prog === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	//------------------------------------------------------------
	// shared tasks
	//------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// reply is the expected body plus a truncated sum of everything exchanged
	task automatic chk_reply(input logic [7:0] w[$], input logic [7:0] e[$], input logic [7:0] r[$]);
		e.push_back(bsum(w) + AR + bsum(e));
		check(r.size(), e.size());
		foreach (e[i]) if (i < r.size()) check(r[i], e[i]);
	endtask : chk_reply
	task automatic upd(input logic [7:0] c);
		@(negedge clk_i);
		upd_valid <= 1'b1;
		upd_code <= c;
		@(negedge clk_i);
		upd_valid <= 1'b0;
		upd_code <= 8'($urandom);
		@(negedge clk_i);
	endtask : upd
	task automatic exitm(input logic [7:0] m, input logic good);
		logic [7:0] cs;
		cs = AW + CMD_EXIT + m + {7'h00, !good};
		u_host.xfer('{AW, CMD_EXIT, m, cs}, 0, rd);
		repeat (20) @(negedge clk_i);
	endtask : exitm
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		void'($urandom(87561));
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		check({status, 2'(active), tx_valid, mem_req, load.req}, {8'h00, 2'h1, 3'h0});
		$display("test reset done");
		// read-back blocks, second half of a row on odd passes only, from the advanced address
		for (int k = 0; k < 4; k++) begin
			page = 8'($urandom);
			mid = (k == 0) ? 8'hFF : 8'($urandom);
			low = {4'($urandom), 1'b0, 3'h0} + ((k % 2) * 8);
			wr = '{AW, CMD_RD_ADDR, 8'h02, mid, low};
			u_host.xfer(wr, 10, rd);
			ex = '{8'h08};
			for (int i = 0; i < 8; i++) ex.push_back(mem_byte({page, 16'({mid, low} + i)}));
			chk_reply(wr, ex, rd);
		end
		u_host.xfer('{AW, CMD_RD_ADDR, 8'h03, 8'h01, 8'h02, 8'h03}, 0, rd);
		repeat (2) @(negedge clk_i);
		check(status, ST_LEN);
		$display("test read-back done");
		// every status code is captured and read back
		ex.delete();
		ex = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B, 8'h0C, 8'h0D, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
			8'hF0, 8'hFF, 8'h00};
		foreach (ex[i]) begin
			upd(ex[i]);
			check(status, ex[i]);
			u_host.xfer('{AW, CMD_STATUS}, 2, rd);
			chk_reply('{AW, CMD_STATUS}, '{ex[i]}, rd);
		end
		upd(8'h57);
		u_host.xfer('{AW, CMD_STATUS, 8'h00}, 0, rd);
		repeat (2) @(negedge clk_i);
		check(status, 8'h00);
		upd(8'h0C);
		u_host.xfer('{AW, CMD_STATUS, 8'h07}, 0, rd);
		repeat (2) @(negedge clk_i);
		check({status, 8'(fails)}, {8'h0C, 8'h01});
		upd(8'h0D);
		check(status, 8'h0D);
		$display("test status done");
		// region switching with fallback on a failed load
		exitm(8'h02, 1'b1);
		check(active, 2'h2);
		fail_next = 1;
		exitm(8'h01, 1'b1);
		check(active, 2'h2);
		exitm(8'h00, 1'b1);
		exitm(8'h03, 1'b1);
		check(regions.size(), 4);
		foreach (regions[i]) check(regions[i], i == 1 ? 2'h1 : 2'h2);
		exitm(8'h02, 1'b0);
		check({status, 8'(exits)}, {8'h01, 8'h04});
		exitm(8'h04, 1'b1);
		check(status, 8'h06);
		$display("test exit done");
		// firmware info for each selector with either image running
		for (int m = 1; m <= 2; m++) begin
			exitm(8'(m), 1'b1);
			wr.delete();
			for (int s = 0; s < 3; s++) begin
				info_rev = {$urandom, $urandom};
				mid = (s == 0) ? 8'h0A : (s == 1) ? 8'h0B : 8'h00;
				wr = '{AW, CMD_INFO, 8'h01, mid};
				u_host.xfer(wr, 11, rd);
				ex = '{8'h09, {7'h00, (mid == 8'h0A && m == 1) || (mid == 8'h0B && m == 2)}};
				for (int i = 0; i < 8; i++) ex.push_back(info_rev[8 * i +: 8]);
				chk_reply(wr, ex, rd);
				check(info_sel, mid);
			end
		end
		u_host.xfer('{AW, CMD_INFO, 8'h01, 8'h07}, 0, rd);
		repeat (2) @(negedge clk_i);
		check({status, 8'(exits)}, {8'h06, 8'h06});
		$display("test info done");
		wrap_up();
	end
endmodule : testbench
